// [hw/adc_result_format_regs.sv]
// Register side of a 10-bit converter: control, config and result bytes on APB.
// Assumes a converter core on ref_clk_i that pulses done with its result.
//
// Overview of operation
// RULE_01 - Left: result bits 1..0 to low 7..6
// RULE_02 - Right: result bits 9..8 to high 1..0
// RULE_03 - Right: result bits 7..0 fill low byte
// RULE_04 - Result bytes writable, kept over resets
// RULE_05 - Software waits acquisition before start
// RULE_06 - Config register bit layout as defined
// RULE_07 - Unused six result bits load zero
// RULE_08 - Left: result bits 9..2 to high
// RULE_09 - Run flag starts, busy, self-clears
// RULE_10 - Format fixed at result load time
`timescale 1ns/100ps
module adc_result_format_regs
   import adc_regs_pkg::*;
(
   // Clock, reset, enable
   input  wire logic               ref_clk_i,
   input  wire logic               rst_i,
   input  wire logic               clk_en_i,
   // APB slave
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [7:0]         paddr_i,
   input  wire logic [31:0]        pwdata_i,
   output logic      [31:0]        prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   // Converter core
   input  wire core_result_t       core_res_i,
   output logic                    core_start_o,
   output core_cfg_t               core_cfg_o,
   output logic                    acq_ok_o
);

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]  ctrl, next_ctrl;           // Control register
   logic [7:0]  cfg, next_cfg;             // Config register
   logic [7:0]  res_high, next_res_high;   // Result high byte
   logic [7:0]  res_low, next_res_low;     // Result low byte
   logic [15:0] acq_len, next_acq_len;     // Acquisition length in cycles
   logic [15:0] acq_cnt, next_acq_cnt;     // Cycles since channel change
   logic        start, next_start;         // Start pulse to core
   logic [31:0] rdata, next_rdata;         // Read data register
   logic [7:0]  pk_high;                   // Packed bytes for current result
   logic [7:0]  pk_low;

   // Write in the access phase, read in the setup phase; this slave answers with no wait
   logic acc_wr;
   logic acc_rd;
   assign pready_o  = 1'b1;
   assign acc_wr    = psel_i && penable_i && pwrite_i && clk_en_i;
   assign acc_rd    = psel_i && !penable_i && !pwrite_i && clk_en_i;

   // Address decode, used by the error flag only
   function automatic logic mapped(input logic [7:0] a);
      return (a == ctrl_addr) || (a == cfg_addr) || (a == res_high_addr) ||
             (a == res_low_addr) || (a == acq_addr);
   endfunction
   assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);

   ////////////////////////////////////////////////////////////////////////
   // Packing of the incoming result under the justification now set
   result_packer u_pack (
      .value_i (core_res_i.value),
      .right_i (cfg[cfg_just_bit]),
      .high_o  (pk_high),
      .low_o   (pk_low)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next-state of the register file
   always_comb begin
      next_ctrl     = ctrl;
      next_cfg      = cfg;
      next_res_high = res_high;
      next_res_low  = res_low;
      next_acq_len  = acq_len;
      next_acq_cnt  = acq_cnt;
      next_start    = 1'b0;
      next_rdata    = rdata;
      // Acquisition counter stops at the length; a shorter length written later
      // must not let it run on and wrap through the whole 16-bit range
      if (acq_cnt < acq_len)
         next_acq_cnt = acq_cnt + 16'h0001;
      if (acc_wr) begin
         unique case (paddr_i)
            ctrl_addr: begin
               next_ctrl = pwdata_i[7:0] & ctrl_impl_mask;
               // RULE_09 - setting run starts
               if (pwdata_i[ctrl_run_bit] && !ctrl[ctrl_run_bit])
                  next_start = 1'b1;
               // Channel change restarts the acquisition wait
               if (pwdata_i[ctrl_chan_lsb +: ctrl_chan_w] !=
                   ctrl[ctrl_chan_lsb +: ctrl_chan_w])
                  next_acq_cnt = 16'h0000;
            end
            // RULE_06 - config layout, bit 3 zero
            cfg_addr:      next_cfg      = pwdata_i[7:0] & cfg_impl_mask;
            // RULE_04 - software may write results
            res_high_addr: next_res_high = pwdata_i[7:0];
            res_low_addr:  next_res_low  = pwdata_i[7:0];
            acq_addr:      next_acq_len  = pwdata_i[15:0];
            default:       next_ctrl     = ctrl;
         endcase
      end
      // RULE_10 - pack at load time
      // RULE_09 - hardware clears run flag; completion wins over a write
      if (core_res_i.done && clk_en_i && ctrl[ctrl_run_bit]) begin
         next_res_high             = pk_high;
         next_res_low              = pk_low;
         next_ctrl[ctrl_run_bit]   = 1'b0;
      end
      if (acc_rd) begin
         unique case (paddr_i)
            ctrl_addr:     next_rdata = {24'h00_0000, ctrl};
            cfg_addr:      next_rdata = {24'h00_0000, cfg};
            res_high_addr: next_rdata = {24'h00_0000, res_high};
            res_low_addr:  next_rdata = {24'h00_0000, res_low};
            acq_addr:      next_rdata = {16'h0000, acq_len};
            default:       next_rdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers; result bytes have no reset so any reset leaves them as-is
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ctrl    <= ctrl_reset;
         cfg     <= cfg_reset;
         acq_len <= acq_reset;
         acq_cnt <= 16'h0000;
         start   <= 1'b0;
         rdata   <= 32'h0000_0000;
      end else if (clk_en_i) begin
         ctrl    <= next_ctrl;
         cfg     <= next_cfg;
         acq_len <= next_acq_len;
         acq_cnt <= next_acq_cnt;
         start   <= next_start;
         rdata   <= next_rdata;
      end
   end

   // RULE_04 - undefined at power-on, kept on reset
   always_ff @(posedge ref_clk_i) begin
      if (clk_en_i) begin
         res_high <= next_res_high;
         res_low  <= next_res_low;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata_o           = rdata;
   assign core_start_o       = start;
   assign core_cfg_o.channel = ctrl[ctrl_chan_lsb +: ctrl_chan_w];
   assign core_cfg_o.enable  = ctrl[ctrl_en_bit];
   assign core_cfg_o.clk_div = cfg[cfg_clk_lsb +: cfg_clk_w];
   assign core_cfg_o.neg_ref = cfg[cfg_nref_bit];
   assign core_cfg_o.pos_ref = cfg[cfg_pref_lsb +: cfg_pref_w];
   // RULE_05 - shows acquisition elapsed
   assign acq_ok_o           = (acq_cnt >= acq_len);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   chk_right_high_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_07
      core_res_i.done && clk_en_i && ctrl[ctrl_run_bit] && cfg[cfg_just_bit]
      |=> res_high[7:2] == 6'h00)
      else $error("right justified high byte not zero filled");
   chk_left_low_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_01
      core_res_i.done && clk_en_i && ctrl[ctrl_run_bit] && !cfg[cfg_just_bit]
      |=> res_low == {$past(core_res_i.value[1:0]), 6'h00})
      else $error("left justified low byte wrong");
   chk_right_high_val: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_02
      core_res_i.done && clk_en_i && ctrl[ctrl_run_bit] && cfg[cfg_just_bit]
      |=> res_high[1:0] == $past(core_res_i.value[9:8]))
      else $error("right justified high bits wrong");
   chk_right_low_val: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_03
      core_res_i.done && clk_en_i && ctrl[ctrl_run_bit] && cfg[cfg_just_bit]
      |=> res_low == $past(core_res_i.value[7:0]))
      else $error("right justified low byte wrong");
   chk_left_high_val: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_08
      core_res_i.done && clk_en_i && ctrl[ctrl_run_bit] && !cfg[cfg_just_bit]
      |=> res_high == $past(core_res_i.value[9:2]))
      else $error("left justified high byte wrong");
   chk_run_start: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_09
      acc_wr && paddr_i == ctrl_addr && pwdata_i[ctrl_run_bit] && !ctrl[ctrl_run_bit]
      |=> core_start_o && ctrl[ctrl_run_bit] ##1 !core_start_o)
      else $error("run flag did not start one pulse");
   chk_run_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_09
      core_res_i.done && clk_en_i && ctrl[ctrl_run_bit] |=> !ctrl[ctrl_run_bit])
      else $error("run flag not cleared on completion");
   chk_cfg_bit3: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_06
      cfg[3] == 1'b0)
      else $error("config bit 3 not zero");
   chk_result_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_10
      acc_wr && paddr_i == cfg_addr && !(core_res_i.done && ctrl[ctrl_run_bit])
      |=> $stable(res_high) && $stable(res_low))
      else $error("stored result reformatted");
   chk_acq_restart: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_05
      acc_wr && paddr_i == ctrl_addr &&
      pwdata_i[6:2] != ctrl[6:2] && acq_len != 16'h0000 |=> !acq_ok_o)
      else $error("channel change did not restart acquisition");

   cov_left_load: cover property (@(posedge ref_clk_i)
      core_res_i.done && ctrl[ctrl_run_bit] && !cfg[cfg_just_bit]);
   cov_right_load: cover property (@(posedge ref_clk_i)
      core_res_i.done && ctrl[ctrl_run_bit] && cfg[cfg_just_bit]);
   cov_start: cover property (@(posedge ref_clk_i) core_start_o);

endmodule

// [hw/adc_regs_pkg.sv]
// Package for the converter register block: offsets, field layouts, reset values,
// carrier structs and timing constants.
// Assumes a 32-bit APB master and a converter core on the same clock.
package adc_regs_pkg;

   // Register byte addresses (one aligned word each)
   localparam logic [7:0] ctrl_addr      = 8'h00;
   localparam logic [7:0] cfg_addr       = 8'h04;
   localparam logic [7:0] res_high_addr  = 8'h08;
   localparam logic [7:0] res_low_addr   = 8'h0C;
   localparam logic [7:0] acq_addr       = 8'h10;

   // Control register fields
   localparam int ctrl_chan_lsb = 2;   // Channel select bits 6..2
   localparam int ctrl_chan_w   = 5;
   localparam int ctrl_run_bit  = 1;   // Conversion run flag
   localparam int ctrl_en_bit   = 0;   // Converter enable

   // Config register fields
   localparam int cfg_just_bit  = 7;   // Justification select, 1 = right
   localparam int cfg_clk_lsb   = 4;   // Clock divider select bits 6..4
   localparam int cfg_clk_w     = 3;
   localparam int cfg_nref_bit  = 2;   // Negative reference select
   localparam int cfg_pref_lsb  = 0;   // Positive reference select bits 1..0
   localparam int cfg_pref_w    = 2;

   // Reset values and field widths
   localparam logic [7:0] ctrl_reset    = 8'h00;
   localparam logic [7:0] cfg_reset     = 8'h00;
   localparam logic [7:0] cfg_impl_mask = 8'hF7;  // Bit 3 reads as zero
   localparam logic [7:0] ctrl_impl_mask = 8'h7F; // Bit 7 reads as zero
   localparam int         result_w      = 10;
   localparam int         zero_w        = 6;
   localparam logic       just_right    = 1'b1;

   // Acquisition interval: printed example figure in ns, cycles at 10 MHz
   localparam int acq_time_ns  = 4420;
   localparam int clk_period_ns = 100;
   localparam int acq_cycles   = (acq_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam logic [15:0] acq_reset = 16'(acq_cycles);

   // Settings the converter core needs
   typedef struct packed {
      logic [4:0] channel;
      logic [2:0] clk_div;
      logic       neg_ref;
      logic [1:0] pos_ref;
      logic       enable;
   } core_cfg_t;

   // Completion from the core
   typedef struct packed {
      logic        done;
      logic [9:0]  value;
   } core_result_t;

endpackage

// [hw/result_packer.sv]
// Packs a 10-bit conversion result into the high and low result bytes.
// Assumes the caller samples the outputs only when it loads a result.
`timescale 1ns/100ps
module result_packer
   import adc_regs_pkg::*;
(
   // Inputs
   input  wire logic [9:0] value_i,
   input  wire logic       right_i,
   // Outputs
   output logic      [7:0] high_o,
   output logic      [7:0] low_o
);

   // Pure combinational packing
   always_comb begin
      if (right_i == just_right) begin
         // RULE_02 - top bits low
         high_o = {{zero_w{1'b0}}, value_i[9:8]};
         // RULE_03 - bits seven..zero
         low_o  = value_i[7:0];
      end else begin
         // RULE_08 - bits nine..two high
         high_o = value_i[9:2];
         // RULE_01 - bits one..zero top
         // RULE_07 - zero fill six bits
         low_o  = {value_i[1:0], {zero_w{1'b0}}};
      end
   end

endmodule

// [verification/tb_top.sv]
// Self-checking bench for the converter register block.
// Assumes the block answers APB at once; this bench plays the converter core.
`timescale 1ns/100ps
module tb_top
   import adc_regs_pkg::*;
();

////////////////////////////////////////////////////////////////////////////////
// Bench signals
logic               ref_clk_i;
logic               rst_i;
logic               clk_en_i;
logic               psel_i;
logic               penable_i;
logic               pwrite_i;
logic [7:0]         paddr_i;
logic [31:0]        pwdata_i;
logic [31:0]        prdata_o;
logic               pready_o;
logic               pslverr_o;
core_result_t       core_res_i;
logic               core_start_o;
core_cfg_t          core_cfg_o;
logic               acq_ok_o;
int                 failures;
int                 n_tests;
int                 seed;
logic [31:0]        q;
logic               err;
logic [15:0]        exp_res;
logic [9:0]         v;
logic               r;

adc_result_format_regs uut (
   .ref_clk_i   (ref_clk_i),
   .rst_i       (rst_i),
   .clk_en_i    (clk_en_i),
   .psel_i      (psel_i),
   .penable_i   (penable_i),
   .pwrite_i    (pwrite_i),
   .paddr_i     (paddr_i),
   .pwdata_i    (pwdata_i),
   .prdata_o    (prdata_o),
   .pready_o    (pready_o),
   .pslverr_o   (pslverr_o),
   .core_res_i  (core_res_i),
   .core_start_o(core_start_o),
   .core_cfg_o  (core_cfg_o),
   .acq_ok_o    (acq_ok_o)
);

// Free-running 10 MHz clock
initial begin
   ref_clk_i = 1'b0;
   forever #50 ref_clk_i = ~ref_clk_i;
end

////////////////////////////////////////////////////////////////////////////////
// Helpers
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   n_tests++;
   if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
   end
endtask

task automatic wrap_up();
   $display("Checks %0d, mismatches %0d", n_tests, failures);
   if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
   end else begin
      $display("Result: failed");
   end
   $finish;
endtask

// One APB transfer; request held until pready is seen at an edge
task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
   int i;
   @(posedge ref_clk_i);
   psel_i <= 1'b1;
   pwrite_i <= wr;
   paddr_i <= a;
   pwdata_i <= d;
   @(posedge ref_clk_i);
   penable_i <= 1'b1;
   for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (pready_o === 1'b1) break;
   end
   // A slave that never answers ends the run
   if (i == 20) begin
      failures++;
      wrap_up();
   end
   q = prdata_o;
   err = pslverr_o;
   psel_i <= 1'b0;
   penable_i <= 1'b0;
endtask

// Bounded wait for the acquisition interval to run out
task automatic wait_ok(input int lim);
   int i;
   for (i = 0; i < lim && acq_ok_o !== 1'b1; i++) @(posedge ref_clk_i);
   if (i == lim) begin
      failures++;
      wrap_up();
   end
endtask

// Core completion: one-cycle done with its value
task automatic pulse_done(input logic [9:0] val);
   @(posedge ref_clk_i);
   core_res_i <= '{done: 1'b1, value: val};
   @(posedge ref_clk_i);
   core_res_i.done <= 1'b0;
endtask

// Expected {high, low} bytes for a result and justification
function automatic logic [15:0] pack(input logic [9:0] val, input logic rj);
   if (rj) return {6'h00, val[9:8], val[7:0]};
   return {val[9:2], val[1:0], 6'h00};
endfunction

////////////////////////////////////////////////////////////////////////////////
// Main sequence
initial begin
   {rst_i, clk_en_i, psel_i, penable_i, pwrite_i} = 5'b11000;
   paddr_i = 8'h00;
   pwdata_i = 32'h0000_0000;
   core_res_i = '0;
   failures = 0;
   n_tests = 0;
   seed = 32'h4fd1;
   repeat (10) @(posedge ref_clk_i);
   rst_i <= 1'b0;
   // Give the result bytes known contents before any config change
   apb(1'b1, res_high_addr, 32'h0000_003C);
   apb(1'b1, res_low_addr, 32'h0000_00C3);
   apb(1'b0, res_low_addr, 32'h0000_0000);
   check(q, 32'h0000_00C3);
   apb(1'b0, ctrl_addr, 32'h0000_0000);
   check(q, {24'h00_0000, ctrl_reset});
   apb(1'b0, acq_addr, 32'h0000_0000);
   check(q, {16'h0000, acq_reset});
   // Unmapped place reads zero with an error
   apb(1'b0, 8'h40, 32'h0000_0000);
   check({31'h0, err}, 32'h0000_0001);
   check(q, 32'h0000_0000);
   // Every config bit set; the hole at bit 3 must read zero
   apb(1'b1, cfg_addr, 32'hFFFF_FFFF);
   apb(1'b0, cfg_addr, 32'h0000_0000);
   check(q, 32'h0000_00F7);
   check(32'(core_cfg_o), 32'({5'h00, 3'h7, 1'b1, 2'h3, 1'b0}));
   // Short interval, then a channel change restarts it
   apb(1'b1, acq_addr, 32'h0000_0004);
   wait_ok(60);
   apb(1'b1, ctrl_addr, 32'h0000_0015);
   @(posedge ref_clk_i);
   #1 check({31'h0, acq_ok_o}, 32'h0000_0000);
   wait_ok(12);
   // Conversions: corner values first, then random, both formats
   for (int j = 0; j < 6; j++) begin
      r = j[0];
      v = (j == 0) ? 10'h3FF : (j == 1) ? 10'h000 : 10'($random(seed));
      exp_res = pack(v, r);
      apb(1'b1, cfg_addr, {24'h00_0000, r, 7'h00});
      apb(1'b1, ctrl_addr, 32'h0000_0017);
      #1 check({31'h0, core_start_o}, 32'h0000_0001);
      apb(1'b0, ctrl_addr, 32'h0000_0000);
      check(q & 32'h0000_0002, 32'h0000_0002);
      pulse_done(v);
      apb(1'b0, ctrl_addr, 32'h0000_0000);
      check(q & 32'h0000_0002, 32'h0000_0000);
      // Flip the format after the load; stored bytes must not move
      if (j >= 4) apb(1'b1, cfg_addr, {24'h00_0000, ~r, 7'h00});
      apb(1'b0, res_high_addr, 32'h0000_0000);
      check(q, {24'h00_0000, exp_res[15:8]});
      apb(1'b0, res_low_addr, 32'h0000_0000);
      check(q, {24'h00_0000, exp_res[7:0]});
   end
   // Frozen while the enable is low: a completion then is not taken
   apb(1'b1, ctrl_addr, 32'h0000_0017);
   @(posedge ref_clk_i);
   clk_en_i <= 1'b0;
   pulse_done(10'h155);
   clk_en_i <= 1'b1;
   apb(1'b0, ctrl_addr, 32'h0000_0000);
   check(q & 32'h0000_0002, 32'h0000_0002);
   pulse_done(10'h155);
   apb(1'b0, ctrl_addr, 32'h0000_0000);
   check(q & 32'h0000_0002, 32'h0000_0000);
   // Result bytes are writable and survive a reset
   apb(1'b1, res_high_addr, 32'h0000_00A5);
   apb(1'b1, res_low_addr, 32'h0000_005A);
   @(posedge ref_clk_i);
   rst_i <= 1'b1;
   @(posedge ref_clk_i);
   rst_i <= 1'b0;
   apb(1'b0, res_high_addr, 32'h0000_0000);
   check(q, 32'h0000_00A5);
   apb(1'b0, res_low_addr, 32'h0000_0000);
   check(q, 32'h0000_005A);
   apb(1'b0, cfg_addr, 32'h0000_0000);
   check(q, {24'h00_0000, cfg_reset});
   wrap_up();
end

endmodule
